// ### src/rtrb_defs.vh
// Register offsets, field positions and reset values of the radio test bank.
`ifndef RTRB_DEFS_VH
`define RTRB_DEFS_VH
// ----------------------------------------------------------------------
// Register offsets (6-bit configuration addresses)
// ----------------------------------------------------------------------
`define RTRB_ADDR_FILTER 6'h2B
`define RTRB_ADDR_FSM 6'h2C
`define RTRB_ADDR_ADC 6'h2D
`define RTRB_ADDR_DAC 6'h2E
`define RTRB_ADDR_TOP 6'h2F
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTRB_FLT_OE_BIT 14
`define RTRB_FLT_OV_MSB 13
`define RTRB_FLT_OV_LSB 7
`define RTRB_FLT_RES_MSB 6
`define RTRB_FLT_RES_LSB 0
`define RTRB_FSM_MSB 5
`define RTRB_FSM_LSB 0
`define RTRB_ADC_CLKDIS_BIT 15
`define RTRB_ADC_I_MSB 14
`define RTRB_ADC_I_LSB 8
`define RTRB_ADC_Q_MSB 6
`define RTRB_ADC_Q_LSB 0
`define RTRB_DAC_SOURCE_SELECT_MSB 14
`define RTRB_DAC_SOURCE_SELECT_LSB 12
`define RTRB_DAC_I_MSB 11
`define RTRB_DAC_I_LSB 6
`define RTRB_DAC_Q_MSB 5
`define RTRB_DAC_Q_LSB 0
`define RTRB_TOP_BIST_BIT 7
`define RTRB_TOP_BATT_BIT 6
`define RTRB_TOP_VCDRV_BIT 5
`define RTRB_TOP_PD_BIT 4
`define RTRB_TOP_MODE_MSB 3
`define RTRB_TOP_MODE_LSB 0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTRB_RST_FILTER 16'h0000
`define RTRB_RST_ADC 16'h0000
`define RTRB_RST_DAC 16'h0000
`define RTRB_RST_TOP 16'h0010
// ----------------------------------------------------------------------
// DAC source and analog test mode codes
// ----------------------------------------------------------------------
`define RTRB_DSRC_MOD 3'h0
`define RTRB_DSRC_OVR 3'h1
`define RTRB_DSRC_ADCHI 3'h2
`define RTRB_DSRC_CHFLT 3'h3
`define RTRB_DSRC_NOISE 3'h4
`define RTRB_DSRC_ADCLO 3'h5
`define RTRB_DSRC_RSSI 3'h6
`define RTRB_DSRC_DEBUG 3'h7
`define RTRB_AMODE_RECEIVE_MIXER 4'h0
`define RTRB_AMODE_BPFIN 4'h1
`define RTRB_AMODE_VGA 4'h2
`define RTRB_AMODE_ADCIN 4'h3
`define RTRB_AMODE_LPF 4'h4
`define RTRB_AMODE_TRANSMIT_MIXER 4'h5
`define RTRB_AMODE_PRESC 4'h6
`define RTRB_AMODE_LOOP 4'h7
`define RTRB_AMODE_THRU 4'h8
`endif

// ### src/rtrb_radio_test_register_bank.v
// Radio test and diagnostic register bank with its steering logic.
`timescale 1ns/1ns
`include "rtrb_defs.vh"

module rtrb_radio_test_register_bank #(
   parameter DATA_W = 16,
   parameter ADDR_W = 6,
   parameter CAP_W = 7,
   parameter ADC_W = 7,
   parameter DAC_W = 6,
   parameter STATE_W = 6
) (
   input wire clk_sys,
   input wire srst,
   input wire regWrite,
   input wire regRead,
   input wire [ADDR_W-1:0] regAddr,
   input wire [DATA_W-1:0] regWrData,
   output reg [DATA_W-1:0] regRdData,
   output reg regRdValid,
   input wire [CAP_W-1:0] filterCapCalResult,
   input wire [STATE_W-1:0] frameFsmCurrentState,
   input wire [ADC_W-1:0] adcSampleI,
   input wire [ADC_W-1:0] adcSampleQ,
   input wire adcEnable,
   input wire [DAC_W-1:0] modDacI,
   input wire [DAC_W-1:0] modDacQ,
   input wire [DAC_W-1:0] chanFiltDacI,
   input wire [DAC_W-1:0] chanFiltDacQ,
   input wire [DAC_W-1:0] noiseDacI,
   input wire [DAC_W-1:0] noiseDacQ,
   input wire [DAC_W-1:0] rssiDacI,
   input wire [DAC_W-1:0] rssiDacQ,
   input wire [DAC_W-1:0] debugDacI,
   input wire [DAC_W-1:0] debugDacQ,
   output wire [CAP_W-1:0] filterCapSetting,
   output wire adcClockEnable,
   output reg [DAC_W-1:0] txDacI,
   output reg [DAC_W-1:0] txDacQ,
   output wire ramSelfTestRun,
   output wire batteryMonitorTestOutEnable,
   output wire analogTestPowerdown,
   output reg [8:0] analogTestRoute,
   output wire vcoNodeOutputSelect,
   output wire vcoNodeDriveSelect
);

   // ----------------------------------------------------------------------
   // Address decoding
   // ----------------------------------------------------------------------
   // One bit per mapped word; write and read share this decode so the two
   // paths can never disagree on which word an address reaches.
   localparam [4:0] SEL_FILTER = 5'h01;
   localparam [4:0] SEL_FSM = 5'h02;
   localparam [4:0] SEL_ADC = 5'h04;
   localparam [4:0] SEL_DAC = 5'h08;
   localparam [4:0] SEL_TOP = 5'h10;

   function [4:0] regSelect;
      input [ADDR_W-1:0] addr;
      begin
         case (addr)
            `RTRB_ADDR_FILTER: begin
               regSelect = SEL_FILTER;
            end
            `RTRB_ADDR_FSM: begin
               regSelect = SEL_FSM;
            end
            `RTRB_ADDR_ADC: begin
               regSelect = SEL_ADC;
            end
            `RTRB_ADDR_DAC: begin
               regSelect = SEL_DAC;
            end
            `RTRB_ADDR_TOP: begin
               regSelect = SEL_TOP;
            end
            default: begin
               regSelect = 5'h00;
            end
         endcase
      end
   endfunction

   wire [4:0] wrSelect;
   assign wrSelect = regWrite ? regSelect(regAddr) : 5'h00;

   // ----------------------------------------------------------------------
   // Writable fields
   // ----------------------------------------------------------------------
   reg [DATA_W-1:0] filterReg_q;
   reg [DATA_W-1:0] adcReg_q;
   reg [DATA_W-1:0] dacReg_q;
   reg [DATA_W-1:0] topReg_q;

   // Write masks keep only writable bits; reserved bits hold zero even
   // if the host breaks its promise to write them as zero.
   localparam [DATA_W-1:0] FILTER_WMASK = 16'h7F80;
   localparam [DATA_W-1:0] ADC_WMASK = 16'h8000;
   localparam [DATA_W-1:0] DAC_WMASK = 16'h7FFF;
   localparam [DATA_W-1:0] TOP_WMASK = 16'h00FF;

   always @(posedge clk_sys) begin
      if (srst) begin
         filterReg_q <= `RTRB_RST_FILTER;
         adcReg_q <= `RTRB_RST_ADC;
         dacReg_q <= `RTRB_RST_DAC;
         topReg_q <= `RTRB_RST_TOP;
      end else begin
         if (wrSelect == SEL_FILTER) begin
            filterReg_q <= regWrData & FILTER_WMASK;
         end
         if (wrSelect == SEL_ADC) begin
            adcReg_q <= regWrData & ADC_WMASK;
         end
         if (wrSelect == SEL_DAC) begin
            dacReg_q <= regWrData & DAC_WMASK;
         end
         if (wrSelect == SEL_TOP) begin
            topReg_q <= regWrData & TOP_WMASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Result sampling
   // ----------------------------------------------------------------------
   // Results come from analog or other logic and are captured once per
   // clock so that a read returns one coherent snapshot.
   reg [CAP_W-1:0] capRes_q;
   reg [STATE_W-1:0] frame_fsm_state_info_q;
   reg [ADC_W-1:0] adcI_q;
   reg [ADC_W-1:0] adcQ_q;

   always @(posedge clk_sys) begin
      if (srst) begin
         capRes_q <= {CAP_W{1'b0}};
         frame_fsm_state_info_q <= {STATE_W{1'b0}};
         adcI_q <= {ADC_W{1'b0}};
         adcQ_q <= {ADC_W{1'b0}};
      end else begin
         capRes_q <= filterCapCalResult;
         frame_fsm_state_info_q <= frameFsmCurrentState;
         adcI_q <= adcSampleI;
         adcQ_q <= adcSampleQ;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   function [DATA_W-1:0] readWord;
      input [4:0] sel;
      begin
         case (sel)
            SEL_FILTER: begin
               readWord = {1'b0, filterReg_q[`RTRB_FLT_OE_BIT],
                  filterReg_q[`RTRB_FLT_OV_MSB:`RTRB_FLT_OV_LSB],
                  capRes_q};
            end
            SEL_FSM: begin
               readWord = {10'h000, frame_fsm_state_info_q};
            end
            SEL_ADC: begin
               readWord = {adcReg_q[`RTRB_ADC_CLKDIS_BIT], adcI_q,
                  1'b0, adcQ_q};
            end
            SEL_DAC: begin
               readWord = dacReg_q;
            end
            SEL_TOP: begin
               readWord = topReg_q;
            end
            default: begin
               readWord = 16'h0000;
            end
         endcase
      end
   endfunction

   always @(posedge clk_sys) begin
      if (srst) begin
         regRdData <= 16'h0000;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead) begin
            regRdData <= readWord(regSelect(regAddr));
         end
      end
   end

   // ----------------------------------------------------------------------
   // Filter and ADC control
   // ----------------------------------------------------------------------
   assign filterCapSetting = filterReg_q[`RTRB_FLT_OE_BIT] ?
      filterReg_q[`RTRB_FLT_OV_MSB:`RTRB_FLT_OV_LSB] :
      capRes_q;

   assign adcClockEnable = adcEnable &
      ~adcReg_q[`RTRB_ADC_CLKDIS_BIT];

   // ----------------------------------------------------------------------
   // TX DAC source routing
   // ----------------------------------------------------------------------
   wire [2:0] dacSourceSelect;
   assign dacSourceSelect = dacReg_q[`RTRB_DAC_SOURCE_SELECT_MSB:`RTRB_DAC_SOURCE_SELECT_LSB];

   wire [DAC_W-1:0] dacOvrI;
   wire [DAC_W-1:0] dacOvrQ;
   assign dacOvrI = dacReg_q[`RTRB_DAC_I_MSB:`RTRB_DAC_I_LSB];
   assign dacOvrQ = dacReg_q[`RTRB_DAC_Q_MSB:`RTRB_DAC_Q_LSB];
   wire [DAC_W-1:0] adcHighI;
   wire [DAC_W-1:0] adcHighQ;
   wire [DAC_W-1:0] adcLowI;
   wire [DAC_W-1:0] adcLowQ;
   // An ADC word is one bit wider than a DAC lane: the high choice drops
   // the least significant bit and the low choice the most significant.
   assign adcHighI = adcI_q[ADC_W-1 -: DAC_W];
   assign adcHighQ = adcQ_q[ADC_W-1 -: DAC_W];
   assign adcLowI = adcI_q[DAC_W-1:0];
   assign adcLowQ = adcQ_q[DAC_W-1:0];

   // Both lanes make the same eight-way choice, so it is decoded once here.
   function [DAC_W-1:0] laneSource;
      input [2:0] sel;
      input [DAC_W-1:0] fromMod;
      input [DAC_W-1:0] fromOvr;
      input [DAC_W-1:0] fromAdcHigh;
      input [DAC_W-1:0] fromChanFilt;
      input [DAC_W-1:0] fromNoise;
      input [DAC_W-1:0] fromAdcLow;
      input [DAC_W-1:0] fromRssi;
      input [DAC_W-1:0] fromDebug;
      begin
         case (sel)
            `RTRB_DSRC_MOD: begin
               laneSource = fromMod;
            end
            `RTRB_DSRC_OVR: begin
               laneSource = fromOvr;
            end
            `RTRB_DSRC_ADCHI: begin
               laneSource = fromAdcHigh;
            end
            `RTRB_DSRC_CHFLT: begin
               laneSource = fromChanFilt;
            end
            `RTRB_DSRC_NOISE: begin
               laneSource = fromNoise;
            end
            `RTRB_DSRC_ADCLO: begin
               laneSource = fromAdcLow;
            end
            `RTRB_DSRC_RSSI: begin
               laneSource = fromRssi;
            end
            default: begin
               laneSource = fromDebug;
            end
         endcase
      end
   endfunction

   always @(posedge clk_sys) begin
      if (srst) begin
         txDacI <= {DAC_W{1'b0}};
         txDacQ <= {DAC_W{1'b0}};
      end else begin
         txDacI <= laneSource(dacSourceSelect,
            modDacI,
            dacOvrI,
            adcHighI,
            chanFiltDacI,
            noiseDacI,
            adcLowI,
            rssiDacI,
            debugDacI);
         txDacQ <= laneSource(dacSourceSelect,
            modDacQ,
            dacOvrQ,
            adcHighQ,
            chanFiltDacQ,
            noiseDacQ,
            adcLowQ,
            rssiDacQ,
            debugDacQ);
      end
   end

   // ----------------------------------------------------------------------
   // Top-level test controls
   // ----------------------------------------------------------------------
   wire [3:0] analogTestMode;
   assign analogTestMode = topReg_q[`RTRB_TOP_MODE_MSB:`RTRB_TOP_MODE_LSB];

   assign ramSelfTestRun = topReg_q[`RTRB_TOP_BIST_BIT];
   assign batteryMonitorTestOutEnable = topReg_q[`RTRB_TOP_BATT_BIT];
   assign analogTestPowerdown = topReg_q[`RTRB_TOP_PD_BIT];

   // ----------------------------------------------------------------------
   // Analog test routing
   // ----------------------------------------------------------------------
   // One-hot route: bit n set selects analog test mode n.
   always @* begin
      analogTestRoute = 9'h000;
      if (!analogTestPowerdown) begin
         case (analogTestMode)
            `RTRB_AMODE_RECEIVE_MIXER: analogTestRoute = 9'h001;
            `RTRB_AMODE_BPFIN: analogTestRoute = 9'h002;
            `RTRB_AMODE_VGA: analogTestRoute = 9'h004;
            `RTRB_AMODE_ADCIN: analogTestRoute = 9'h008;
            `RTRB_AMODE_LPF: analogTestRoute = 9'h010;
            `RTRB_AMODE_TRANSMIT_MIXER: analogTestRoute = 9'h020;
            `RTRB_AMODE_PRESC: analogTestRoute = 9'h040;
            `RTRB_AMODE_LOOP: analogTestRoute = 9'h080;
            `RTRB_AMODE_THRU: analogTestRoute = 9'h100;
            default: analogTestRoute = 9'h000;
         endcase
      end
   end

   assign vcoNodeOutputSelect = analogTestRoute[7] &
      ~topReg_q[`RTRB_TOP_VCDRV_BIT];
   assign vcoNodeDriveSelect = analogTestRoute[7] &
      topReg_q[`RTRB_TOP_VCDRV_BIT];

endmodule // rtrb_radio_test_register_bank

// ### testbench/rtrb_bank_chk.sv
// Port-level checker for the radio test register bank.
`timescale 1ns/1ns
`include "rtrb_defs.vh"
module rtrb_bank_chk #(
   parameter DATA_W = 16,
   parameter ADDR_W = 6,
   parameter DAC_W = 6
) (
   input wire clk_sys,
   input wire srst,
   input wire regWrite,
   input wire regRead,
   input wire [ADDR_W-1:0] regAddr,
   input wire [DATA_W-1:0] regWrData,
   input wire regRdValid,
   input wire adcEnable,
   input wire adcClockEnable,
   input wire [DAC_W-1:0] txDacI,
   input wire [DAC_W-1:0] txDacQ,
   input wire ramSelfTestRun,
   input wire analogTestPowerdown,
   input wire [8:0] analogTestRoute,
   input wire vcoNodeOutputSelect,
   input wire vcoNodeDriveSelect
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire wrTop = regWrite && regAddr == `RTRB_ADDR_TOP;
   wire wrDac = regWrite && regAddr == `RTRB_ADDR_DAC;
   wire vcoAny = vcoNodeOutputSelect || vcoNodeDriveSelect;
   wire wrAdc = regWrite && regAddr == `RTRB_ADDR_ADC;
   // Shadow of the ADC clock disable bit, rebuilt from the host's writes.
   reg clkDisSeen;
   always @(posedge clk_sys) begin
      if (srst)
         clkDisSeen <= 1'b0;
      else if (wrAdc)
         clkDisSeen <= regWrData[15];
   end
   property p_rdv; regRead |=> regRdValid; endproperty
   a_rdv: assert property (p_rdv) else $error("no read valid");
   property p_bist; wrTop |=> ramSelfTestRun == $past(regWrData[7]); endproperty
   a_bist: assert property (p_bist) else $error("self-test bit");
   property p_pd; wrTop |=> analogTestPowerdown == $past(regWrData[4]);
   endproperty
   a_pd: assert property (p_pd) else $error("power-down bit");
   property p_route; analogTestPowerdown |-> analogTestRoute == 9'h000;
   endproperty
   a_route: assert property (p_route) else $error("route when off");
   property p_hot; $onehot0(analogTestRoute); endproperty
   a_hot: assert property (p_hot) else $error("route not one-hot");
   property p_vco; vcoAny |-> analogTestRoute == 9'h080 &&
      !(vcoNodeOutputSelect && vcoNodeDriveSelect); endproperty
   a_vco: assert property (p_vco) else $error("vco select");
   property p_adc; adcClockEnable == (adcEnable && !clkDisSeen); endproperty
   a_adc: assert property (p_adc) else $error("adc clock");
   property p_dac; wrDac && regWrData[14:12] == 3'h1 ##1 !wrDac |=>
      txDacI == $past(regWrData[11:6], 2) &&
      txDacQ == $past(regWrData[5:0], 2); endproperty
   a_dac: assert property (p_dac) else $error("dac override");
endmodule // rtrb_bank_chk
bind rtrb_radio_test_register_bank rtrb_bank_chk #(.DATA_W(DATA_W),
   .ADDR_W(ADDR_W), .DAC_W(DAC_W)) rtrb_bank_chk_inst (.clk_sys, .srst,
   .regWrite, .regRead, .regAddr, .regWrData, .regRdValid, .adcEnable,
   .adcClockEnable, .txDacI, .txDacQ, .ramSelfTestRun, .analogTestPowerdown,
   .analogTestRoute, .vcoNodeOutputSelect, .vcoNodeDriveSelect);

// ### testbench/rtrb_host_model.sv
// Host model that reaches the test registers through the strobe port.
`timescale 1ns/1ns
module rtrb_host_model (
   input wire clk_sys,
   input wire [15:0] regRdData,
   input wire regRdValid,
   output reg regWrite = 1'b0,
   output reg regRead = 1'b0,
   output reg [5:0] regAddr = 6'h00,
   output reg [15:0] regWrData = 16'h0000
);
   function [15:0] keepMask(input [5:0] a);
      case (a)
         6'h2B, 6'h2E: keepMask = 16'h7FFF;
         6'h2C: keepMask = 16'h003F;
         6'h2D: keepMask = 16'hFF7F;
         6'h2F: keepMask = 16'h00FF;
         default: keepMask = 16'hFFFF;
      endcase
   endfunction
   // Address and data are inverted once released so no stale value lingers.
   task xfer(input w, input [5:0] a, input [15:0] d, output [15:0] q,
      output v);
      begin
         @(negedge clk_sys);
         regAddr = a;
         regWrData = d & keepMask(a);
         regWrite = w;
         regRead = ~w;
         @(negedge clk_sys);
         regWrite = 1'b0;
         regRead = 1'b0;
         q = regRdData;
         v = regRdValid;
         regAddr = ~regAddr;
         regWrData = ~regWrData;
      end
   endtask
endmodule // rtrb_host_model

// ### testbench/rtrb_radio_test_register_bank_bench.sv
// Self-checking bench for the radio test register bank.
`timescale 1ns/1ns
module rtrb_radio_test_register_bank_bench;
   reg clk_sys = 1'b0;
   reg srst = 1'b1;
   reg [6:0] filterCapCalResult = 7'h00, adcSampleI = 7'h00, adcSampleQ = 7'h00;
   reg [5:0] frameFsmCurrentState = 6'h00;
   reg adcEnable = 1'b0;
   reg [5:0] modDacI = 6'h01, modDacQ = 6'h02, chanFiltDacI = 6'h03;
   reg [5:0] chanFiltDacQ = 6'h04, noiseDacI = 6'h05, noiseDacQ = 6'h06;
   reg [5:0] rssiDacI = 6'h07, rssiDacQ = 6'h08, debugDacI = 6'h09;
   reg [5:0] debugDacQ = 6'h0A;
   wire regWrite, regRead, regRdValid, adcClockEnable, ramSelfTestRun;
   wire batteryMonitorTestOutEnable, analogTestPowerdown;
   wire vcoNodeOutputSelect, vcoNodeDriveSelect;
   wire [5:0] regAddr, txDacI, txDacQ;
   wire [15:0] regWrData, regRdData;
   wire [6:0] filterCapSetting;
   wire [8:0] analogTestRoute;
   wire [15:0] topView = {ramSelfTestRun, batteryMonitorTestOutEnable,
      analogTestPowerdown, vcoNodeOutputSelect, vcoNodeDriveSelect, 2'b00,
      analogTestRoute};
   wire [15:0] dacView = {4'h0, txDacI, txDacQ};
   wire [15:0] anaView = {8'h00, adcClockEnable, filterCapSetting};
   integer nMismatch = 0, cmpCount = 0, cyc = 0, i;
   reg [15:0] e;
   rtrb_radio_test_register_bank rtrb_radio_test_register_bank_inst (
      .clk_sys, .srst, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
      .regRdValid, .filterCapCalResult, .frameFsmCurrentState, .adcSampleI,
      .adcSampleQ, .adcEnable, .modDacI, .modDacQ, .chanFiltDacI,
      .chanFiltDacQ, .noiseDacI, .noiseDacQ, .rssiDacI, .rssiDacQ,
      .debugDacI, .debugDacQ, .filterCapSetting, .adcClockEnable, .txDacI,
      .txDacQ, .ramSelfTestRun, .batteryMonitorTestOutEnable,
      .analogTestPowerdown, .analogTestRoute, .vcoNodeOutputSelect,
      .vcoNodeDriveSelect);
   rtrb_host_model rtrb_host_model_inst (.clk_sys, .regRdData, .regRdValid,
      .regWrite, .regRead, .regAddr, .regWrData);
   always #4 clk_sys = ~clk_sys;
   task finishTest;
      begin
         if (nMismatch == 0 && cmpCount > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         nMismatch = nMismatch + 1;
         finishTest;
      end
   end
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         cmpCount = cmpCount + 1;
         if (seen !== exp) begin
            nMismatch = nMismatch + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [5:0] a, input [15:0] d);
      reg [15:0] q;
      reg v;
      begin
         rtrb_host_model_inst.xfer(1'b1, a, d, q, v);
      end
   endtask
   task rdChk(input [5:0] a, input [15:0] x);
      reg [15:0] q;
      reg v;
      begin
         rtrb_host_model_inst.xfer(1'b0, a, 16'h0000, q, v);
         chk({15'h0000, v}, 16'h0001);
         chk(q, x);
      end
   endtask
   task tReset;
      begin
         chk(topView, 16'h2000);
         chk(dacView, 16'h0000);
         chk(regRdData, 16'h0000);
         chk({15'h0000, regRdValid}, 16'h0000);
         @(negedge clk_sys);
         chk(dacView, {4'h0, modDacI, modDacQ});
         rdChk(6'h2B, {9'h000, filterCapCalResult});
         rdChk(6'h2C, {10'h000, frameFsmCurrentState});
         rdChk(6'h2D, {1'b0, adcSampleI, 1'b0, adcSampleQ});
         rdChk(6'h2E, 16'h0000);
         rdChk(6'h2F, 16'h0010);
         rdChk(6'h30, 16'h0000);
      end
   endtask
   task tFilter;
      begin
         @(negedge clk_sys);
         filterCapCalResult = 7'h55;
         wr(6'h2B, 16'hFFFF);
         rdChk(6'h2B, 16'h7FD5);
         chk(anaView, 16'h007F);
         wr(6'h2B, 16'h2A00);
         rdChk(6'h2B, 16'h2A55);
         chk(anaView, 16'h0055);
      end
   endtask
   task tAdc;
      begin
         @(negedge clk_sys);
         frameFsmCurrentState = 6'h2A;
         adcSampleI = 7'h5B;
         adcSampleQ = 7'h26;
         adcEnable = 1'b1;
         rdChk(6'h2C, 16'h002A);
         wr(6'h2D, 16'hFFFF);
         rdChk(6'h2D, 16'hDB26);
         chk(anaView, 16'h0055);
         wr(6'h2D, 16'h0000);
         chk(anaView, 16'h00D5);
         adcEnable = 1'b0;
         #1 chk(anaView, 16'h0055);
      end
   endtask
   task tDac;
      begin
         wr(6'h2F, 16'h0004);
         for (i = 0; i < 8; i = i + 1) begin
            wr(6'h2E, {1'b0, i[2:0], 12'h56A});
            @(negedge clk_sys);
            case (i)
               0: e = {4'h0, modDacI, modDacQ};
               1: e = 16'h056A;
               2: e = {4'h0, adcSampleI[6:1], adcSampleQ[6:1]};
               3: e = {4'h0, chanFiltDacI, chanFiltDacQ};
               4: e = {4'h0, noiseDacI, noiseDacQ};
               5: e = {4'h0, adcSampleI[5:0], adcSampleQ[5:0]};
               6: e = {4'h0, rssiDacI, rssiDacQ};
               default: e = {4'h0, debugDacI, debugDacQ};
            endcase
            chk(dacView, e);
         end
         rdChk(6'h2E, 16'h756A);
      end
   endtask
   task tTop;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            wr(6'h2F, 16'h0020 | i[15:0]);
            e = 16'h0000;
            if (i < 9)
               e[i] = 1'b1;
            if (i == 7)
               e[11] = 1'b1;
            chk(topView, e);
         end
         wr(6'h2F, 16'h0007);
         chk(topView, 16'h1080);
         wr(6'h2F, 16'h00D7);
         chk(topView, 16'hE000);
         rdChk(6'h2F, 16'h00D7);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      srst = 1'b0;
      tReset;
      tFilter;
      tAdc;
      tDac;
      tTop;
      @(negedge clk_sys);
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      tReset;
      finishTest;
   end
endmodule // rtrb_radio_test_register_bank_bench
